// ===== srs_consts.svh
/*
 * constants of the safety relay start logic: register offsets, field positions,
 * reset values, mode selector codes and timing figures.
 * assumes a 125 MHz system clock and a 32-bit register port.
 */
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH

// register offsets (byte addresses)
`define SRS_ADDR_STATUS     8'h00
`define SRS_ADDR_IRQ_EN     8'h04
`define SRS_ADDR_IRQ_CLR    8'h08
`define SRS_ADDR_STATE      8'h0C
`define SRS_ADDR_MODE       8'h10

// event bits of status, enable and clear registers
`define SRS_EV_W            4
`define SRS_EV_ON           0
`define SRS_EV_OFF          1
`define SRS_EV_FAULT        2
`define SRS_EV_BLOCK        3
`define SRS_EV_RESET        4'h0
`define SRS_IRQ_EN_RESET    4'h0

// state register fields
`define SRS_ST_STATE_LSB    0
`define SRS_ST_OUT_BIT      4
`define SRS_ST_BLOCK_BIT    5
`define SRS_ST_FAULT_LSB    8

// fault cause bits
`define SRS_FLT_W           7
`define SRS_FLT_MODE        0
`define SRS_FLT_CHANGE      1
`define SRS_FLT_EARTH       2
`define SRS_FLT_SHORT       3
`define SRS_FLT_CROSS       4
`define SRS_FLT_EXPANSION   5
`define SRS_FLT_RELAY       6

// mode selector: [2:0] start behaviour, [4:3] channel configuration
`define SRS_MODE_W          5
`define SRS_MODE_RESET      5'h1F
`define SRS_MODE_NEUTRAL    5'h1F
`define SRS_KIND_AUTO       3'h0
`define SRS_KIND_MANUAL     3'h1
`define SRS_KIND_RISE       3'h2
`define SRS_KIND_FALL       3'h3
`define SRS_KIND_TEST       3'h4
`define SRS_CH_SINGLE       2'h0
`define SRS_CH_DUAL_NSD     2'h1
`define SRS_CH_DUAL_SD      2'h2

// timing, microseconds and clock rate
`define SRS_CLK_MHZ         125
`define SRS_T_ON_US         50
`define SRS_T_OFF_US        20
`define SRS_T_WAIT_US       250
`define SRS_T_PULSE_US      30
`define SRS_T_FB_US         20
`define SRS_INIT_CYC        3'h7
`define SRS_US2CYC(t)       ((t) * `SRS_CLK_MHZ)

`endif

// ===== srs_pkg.sv
/*
 * types of the safety relay start logic.
 * assumes srs_consts.svh for numeric constants.
 */
package srs_pkg;

	typedef enum logic [2:0] {
		SRS_S_INIT,
		SRS_S_READY,
		SRS_S_ON_DELAY,
		SRS_S_ACTIVE,
		SRS_S_OFF_DELAY,
		SRS_S_FAULT
	} srs_state_type;

endpackage : srs_pkg

// ===== srs_sync.sv
/*
 * three-stage input synchroniser; a bit changes once stages two and three agree.
 * assumes asynchronous pin inputs and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module srs_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_resetn,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] ff1_reg;
	logic [W-1:0] ff2_reg;
	logic [W-1:0] ff3_reg;
	logic [W-1:0] out_reg;

	if (W < 1) begin : g_chk
		$error("srs_sync width must be at least one");
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			ff1_reg <= '0;
			ff2_reg <= '0;
			ff3_reg <= '0;
		end else begin
			ff1_reg <= i_async;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			out_reg <= '0;
		end else begin
			out_reg <= (ff2_reg & ~(ff2_reg ^ ff3_reg)) | (out_reg & (ff2_reg ^ ff3_reg));
		end
	end

	assign o_sync = out_reg;

endmodule : srs_sync

// ===== srs_core.sv
/*
 * dual-channel safety relay start and monitoring logic with register port.
 * assumes pins arrive asynchronously, relay feedback high when a contact is closed,
 * and fault detector inputs high while the fault is present.
 */
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "srs_consts.svh"

// Summary of operation
// - automatic start closes outputs once the input circuit is closed.
// - manual start closes outputs only while input and start circuits are closed.
// - falling-edge start activates when start opens after closing, input closed.
// - rising-edge start needs start closing after the waiting period since input closed.
// - start-up test mode needs input opened then closed after power-up.
// - relay feedback checked every cycle of use; failure blocks reactivation.
// - single channel detects earth faults on start and input circuits.
// - dual channel detects earth faults, input shorts, start shorts in monitored start.
// - dual channel with short detection also detects shorts between channels.
// - selector chooses short detection and one of the start behaviours.
// - neutral selector position gives an error and keeps outputs open.
// - selector change while running faults and locks until reset.
// - separate non-safety auxiliary output for display.
// - automatic or bridged manual start reactivates when input closes again.
// - monitored start ignores start pulses shorter than the minimum.
// - auxiliary output high exactly while safety outputs are closed.
// - one channel interrupted alone blocks power-up until both open together.
// - missing expansion module or terminator faults and keeps outputs off.
module srs_core #(
	parameter int unsigned ON_CYC    = `SRS_US2CYC(`SRS_T_ON_US),
	parameter int unsigned OFF_CYC   = `SRS_US2CYC(`SRS_T_OFF_US),
	parameter int unsigned WAIT_CYC  = `SRS_US2CYC(`SRS_T_WAIT_US),
	parameter int unsigned PULSE_CYC = `SRS_US2CYC(`SRS_T_PULSE_US),
	parameter int unsigned FB_CYC    = `SRS_US2CYC(`SRS_T_FB_US),
	parameter int unsigned CNT_W     = 20
) (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_resetn,
	input  wire logic                  i_input_ch1,
	input  wire logic                  i_input_ch2,
	input  wire logic                  i_start_input,
	input  wire logic [4:0]            i_mode_sel,
	input  wire logic                  i_earth_fault,
	input  wire logic                  i_input_short,
	input  wire logic                  i_start_short,
	input  wire logic                  i_cross_short,
	input  wire logic                  i_expansion_present,
	input  wire logic                  i_relay_fb1,
	input  wire logic                  i_relay_fb2,
	input  wire logic [7:0]            i_addr,
	input  wire logic [31:0]           i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [31:0]           o_rdata,
	output logic                       o_safety_out1,
	output logic                       o_safety_out2,
	output logic                       o_aux_status_out,
	output logic                       o_fault,
	output logic                       o_irq,
	output srs_pkg::srs_state_type     o_state
);
	import srs_pkg::*;

	localparam int unsigned SYNC_W = 15;
	localparam logic [CNT_W-1:0] ON_LIM    = CNT_W'(ON_CYC - 1);
	localparam logic [CNT_W-1:0] OFF_LIM   = CNT_W'(OFF_CYC - 1);
	localparam logic [CNT_W-1:0] WAIT_LIM  = CNT_W'(WAIT_CYC);
	localparam logic [CNT_W-1:0] PULSE_LIM = CNT_W'(PULSE_CYC);
	localparam logic [CNT_W-1:0] FB_LIM    = CNT_W'(FB_CYC);

	if (CNT_W < 2 || CNT_W > 31) begin : g_chk_w
		$error("srs_core counter width out of range");
	end
	if (ON_CYC < 1 || OFF_CYC < 1 || WAIT_CYC < 1 || PULSE_CYC < 1 || FB_CYC < 1) begin : g_chk_min
		$error("srs_core timing counts must be at least one");
	end
	if (ON_CYC >= (2 ** CNT_W) || OFF_CYC >= (2 ** CNT_W) || WAIT_CYC >= (2 ** CNT_W)
		|| PULSE_CYC >= (2 ** CNT_W) || FB_CYC >= (2 ** CNT_W)) begin : g_chk_max
		$error("srs_core timing counts exceed counter width");
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisation

	logic [SYNC_W-1:0] sync_vec;
	logic              ch1;
	logic              ch2;
	logic              st;
	logic [4:0]        mode_now;
	logic              earth;
	logic              in_short;
	logic              st_short;
	logic              x_short;
	logic              exp_ok;
	logic              fb1;
	logic              fb2;

	srs_sync #(
		.W (SYNC_W)
	) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_async   ({i_input_ch1, i_input_ch2, i_start_input, i_mode_sel, i_earth_fault, i_input_short,
		             i_start_short, i_cross_short, i_expansion_present, i_relay_fb1, i_relay_fb2}),
		.o_sync    (sync_vec)
	);

	assign {ch1, ch2, st, mode_now, earth, in_short, st_short, x_short, exp_ok, fb1, fb2} = sync_vec;

	////////////////////////////////////////////////////////////////////////////////
	// mode selector capture

	logic [4:0]  mode_reg;
	logic        mode_valid_reg;
	logic [2:0]  init_cnt_reg;
	logic [2:0]  kind;
	logic [1:0]  chan;
	logic        dual;
	logic        mode_bad;
	logic        monitored;

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			init_cnt_reg   <= 3'h0;
			mode_valid_reg <= 1'b0;
			mode_reg       <= `SRS_MODE_RESET;
		end else if (!mode_valid_reg) begin
			init_cnt_reg <= init_cnt_reg + 3'h1;
			if (init_cnt_reg == `SRS_INIT_CYC) begin
				mode_valid_reg <= 1'b1;
				mode_reg       <= mode_now;
			end
		end
	end

	assign kind      = mode_reg[2:0];
	assign chan      = mode_reg[4:3];
	assign dual      = (chan != `SRS_CH_SINGLE);
	assign monitored = (kind == `SRS_KIND_RISE) || (kind == `SRS_KIND_FALL);
	assign mode_bad  = (mode_reg == `SRS_MODE_NEUTRAL) || (chan == 2'h3) || (kind > `SRS_KIND_TEST);

	////////////////////////////////////////////////////////////////////////////////
	// fault latches, held until reset

	logic [`SRS_FLT_W-1:0] fault_reg;
	logic [`SRS_FLT_W-1:0] fault_now;
	logic                  fault_any;
	logic                  out_reg;
	logic [CNT_W-1:0]      fb_cnt_reg;
	logic                  fb_mism;

	assign fb_mism = ({fb1, fb2} != {out_reg, out_reg});

	always_comb begin
		fault_now = '0;
		if (mode_valid_reg) begin
			fault_now[`SRS_FLT_MODE]      = mode_bad;
			fault_now[`SRS_FLT_CHANGE]    = (mode_now != mode_reg);
			fault_now[`SRS_FLT_EARTH]     = earth;
			fault_now[`SRS_FLT_SHORT]     = dual && (in_short || (monitored && st_short));
			fault_now[`SRS_FLT_CROSS]     = (chan == `SRS_CH_DUAL_SD) && x_short;
			fault_now[`SRS_FLT_EXPANSION] = !exp_ok;
			fault_now[`SRS_FLT_RELAY]     = (fb_cnt_reg >= FB_LIM);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			fault_reg <= '0;
		end else begin
			fault_reg <= fault_reg | fault_now;
		end
	end

	assign fault_any = |fault_reg;

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			fb_cnt_reg <= '0;
		end else if (!fb_mism) begin
			fb_cnt_reg <= '0;
		end else if (fb_cnt_reg < FB_LIM) begin
			fb_cnt_reg <= fb_cnt_reg + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// input circuit, channel discrepancy and start timing

	logic             input_closed;
	logic [1:0]       ch_prev_reg;
	logic             block_reg;
	logic [CNT_W-1:0] wait_cnt_reg;
	logic [CNT_W-1:0] st_cnt_reg;
	logic             st_prev_reg;
	logic             rise_armed_reg;
	logic             fall_armed_reg;
	logic             test_open_reg;
	logic             wait_done;
	logic             pulse_ok;
	logic             fall_go;

	assign input_closed = dual ? (ch1 && ch2) : ch1;
	assign wait_done    = (wait_cnt_reg >= WAIT_LIM);
	assign pulse_ok     = (st_cnt_reg >= PULSE_LIM);
	assign fall_go      = st_prev_reg && !st && fall_armed_reg && input_closed;

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			ch_prev_reg <= 2'h0;
			block_reg   <= 1'b0;
		end else begin
			ch_prev_reg <= {ch1, ch2};
			if (!dual || (!ch1 && !ch2)) begin
				block_reg <= 1'b0;
			end else if ((ch_prev_reg == 2'h3) && (ch1 != ch2)) begin
				block_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			wait_cnt_reg <= '0;
		end else if (!input_closed) begin
			wait_cnt_reg <= '0;
		end else if (!wait_done) begin
			wait_cnt_reg <= wait_cnt_reg + CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			st_cnt_reg  <= '0;
			st_prev_reg <= 1'b0;
		end else begin
			st_prev_reg <= st;
			if (!st) begin
				st_cnt_reg <= '0;
			end else if (!pulse_ok) begin
				st_cnt_reg <= st_cnt_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			rise_armed_reg <= 1'b0;
			fall_armed_reg <= 1'b0;
		end else begin
			if (!st) begin
				rise_armed_reg <= 1'b0;
			end else if (!st_prev_reg) begin
				rise_armed_reg <= wait_done;
			end
			if (!st) begin
				fall_armed_reg <= 1'b0;
			end else if (pulse_ok) begin
				fall_armed_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			test_open_reg <= 1'b0;
		end else if (mode_valid_reg && !input_closed) begin
			test_open_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// start decision and output state machine

	logic             start_ok;
	logic             go;
	logic             hold_ok;
	srs_state_type    state_reg;
	srs_state_type    state_next;
	logic [CNT_W-1:0] timer_reg;

	always_comb begin
		unique case (kind)
			`SRS_KIND_AUTO:   start_ok = input_closed;
			`SRS_KIND_MANUAL: start_ok = input_closed && st;
			`SRS_KIND_RISE:   start_ok = input_closed && rise_armed_reg && pulse_ok;
			`SRS_KIND_FALL:   start_ok = fall_go;
			`SRS_KIND_TEST:   start_ok = input_closed && test_open_reg;
			default:          start_ok = 1'b0;
		endcase
	end

	assign go      = start_ok && !block_reg && !fb1 && !fb2 && !fault_any && mode_valid_reg;
	assign hold_ok = input_closed && !block_reg && ((kind != `SRS_KIND_MANUAL) || st);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SRS_S_INIT: begin
				if (mode_valid_reg) begin
					state_next = SRS_S_READY;
				end
			end
			SRS_S_READY: begin
				if (fault_any) begin
					state_next = SRS_S_FAULT;
				end else if (go) begin
					state_next = SRS_S_ON_DELAY;
				end
			end
			SRS_S_ON_DELAY: begin
				if (fault_any) begin
					state_next = SRS_S_FAULT;
				end else if (!hold_ok) begin
					state_next = SRS_S_READY;
				end else if (timer_reg >= ON_LIM) begin
					state_next = SRS_S_ACTIVE;
				end
			end
			SRS_S_ACTIVE: begin
				if (fault_any) begin
					state_next = SRS_S_FAULT;
				end else if (!hold_ok) begin
					state_next = SRS_S_OFF_DELAY;
				end
			end
			SRS_S_OFF_DELAY: begin
				if (fault_any) begin
					state_next = SRS_S_FAULT;
				end else if (timer_reg >= OFF_LIM) begin
					state_next = SRS_S_READY;
				end
			end
			SRS_S_FAULT: begin
				state_next = SRS_S_FAULT;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			state_reg <= SRS_S_INIT;
			timer_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg) begin
				timer_reg <= '0;
			end else if (timer_reg != {CNT_W{1'b1}}) begin
				timer_reg <= timer_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			out_reg <= 1'b0;
		end else begin
			out_reg <= (state_next == SRS_S_ACTIVE) || (state_next == SRS_S_OFF_DELAY);
		end
	end

	assign o_safety_out1    = out_reg;
	assign o_safety_out2    = out_reg;
	assign o_aux_status_out = out_reg;
	assign o_fault          = fault_any || block_reg;
	assign o_state          = state_reg;

	////////////////////////////////////////////////////////////////////////////////
	// events, interrupt and register port

	logic [`SRS_EV_W-1:0] status_reg;
	logic [`SRS_EV_W-1:0] irq_en_reg;
	logic [`SRS_EV_W-1:0] ev;
	logic [`SRS_EV_W-1:0] clr;
	logic                 out_prev_reg;
	logic                 fault_prev_reg;
	logic                 block_prev_reg;
	logic [31:0]          rdata_reg;

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			out_prev_reg   <= 1'b0;
			fault_prev_reg <= 1'b0;
			block_prev_reg <= 1'b0;
		end else begin
			out_prev_reg   <= out_reg;
			fault_prev_reg <= fault_any;
			block_prev_reg <= block_reg;
		end
	end

	always_comb begin
		ev                = '0;
		ev[`SRS_EV_ON]    = out_reg && !out_prev_reg;
		ev[`SRS_EV_OFF]   = !out_reg && out_prev_reg;
		ev[`SRS_EV_FAULT] = fault_any && !fault_prev_reg;
		ev[`SRS_EV_BLOCK] = block_reg && !block_prev_reg;
		clr               = (i_wr && (i_addr == `SRS_ADDR_IRQ_CLR)) ? i_wdata[`SRS_EV_W-1:0] : '0;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			status_reg <= `SRS_EV_RESET;
		end else begin
			status_reg <= (status_reg & ~clr) | ev;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			irq_en_reg <= `SRS_IRQ_EN_RESET;
		end else if (i_wr && (i_addr == `SRS_ADDR_IRQ_EN)) begin
			irq_en_reg <= i_wdata[`SRS_EV_W-1:0];
		end
	end

	assign o_irq = |(status_reg & irq_en_reg);

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= 32'h0000_0000;
			if (i_rd) begin
				unique case (i_addr)
					`SRS_ADDR_STATUS: rdata_reg[`SRS_EV_W-1:0] <= status_reg;
					`SRS_ADDR_IRQ_EN: rdata_reg[`SRS_EV_W-1:0] <= irq_en_reg;
					`SRS_ADDR_STATE: begin
						rdata_reg[`SRS_ST_STATE_LSB +: 3]          <= state_reg;
						rdata_reg[`SRS_ST_OUT_BIT]                 <= out_reg;
						rdata_reg[`SRS_ST_BLOCK_BIT]               <= block_reg;
						rdata_reg[`SRS_ST_FAULT_LSB +: `SRS_FLT_W] <= fault_reg;
					end
					`SRS_ADDR_MODE:   rdata_reg[`SRS_MODE_W-1:0] <= mode_reg;
					default:          rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign o_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	property p_aux_tracks;
		(o_aux_status_out == o_safety_out1) && (o_safety_out1 == o_safety_out2)
			&& (o_safety_out1 == ((state_reg == SRS_S_ACTIVE) || (state_reg == SRS_S_OFF_DELAY)));
	endproperty
	a_aux_tracks: assert property (p_aux_tracks) else $error("aux output differs from safety outputs");

	property p_on_delay;
		$rose(o_safety_out1) |-> ($past(state_reg) == SRS_S_ON_DELAY) && ($past(timer_reg) == ON_LIM);
	endproperty
	a_on_delay: assert property (p_on_delay) else $error("outputs closed without full switch-on delay");

	property p_off_delay;
		(state_reg == SRS_S_OFF_DELAY) && (timer_reg >= OFF_LIM) |=> !o_safety_out1;
	endproperty
	a_off_delay: assert property (p_off_delay) else $error("outputs held beyond de-energisation delay");

	property p_fault_opens;
		fault_any |=> ##1 !o_safety_out1;
	endproperty
	a_fault_opens: assert property (p_fault_opens) else $error("outputs closed while faulted");

	property p_change_fault;
		mode_valid_reg && (mode_now != mode_reg) |=> fault_reg[`SRS_FLT_CHANGE] ##1 (state_reg == SRS_S_FAULT);
	endproperty
	a_change_fault: assert property (p_change_fault) else $error("selector change not latched as fault");

	property p_neutral;
		mode_valid_reg && (mode_reg == `SRS_MODE_NEUTRAL) |=> o_fault && !o_safety_out1;
	endproperty
	a_neutral: assert property (p_neutral) else $error("neutral selector not flagged");

	property p_auto_start;
		(state_reg == SRS_S_READY) && (kind == `SRS_KIND_AUTO) && input_closed && !block_reg
			&& !fault_any && !fb1 && !fb2 |=> (state_reg == SRS_S_ON_DELAY);
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("automatic start did not begin");

	property p_manual_hold;
		(kind == `SRS_KIND_MANUAL) && (state_reg == SRS_S_ON_DELAY) && !st |=> (state_reg != SRS_S_ACTIVE);
	endproperty
	a_manual_hold: assert property (p_manual_hold) else $error("manual start without start circuit");

	property p_block_hold;
		block_reg && (state_reg == SRS_S_READY) |=> (state_reg != SRS_S_ON_DELAY);
	endproperty
	a_block_hold: assert property (p_block_hold) else $error("start while channel discrepancy blocked");

	property p_relay_fault;
		(fb_cnt_reg >= FB_LIM) && mode_valid_reg |=> fault_reg[`SRS_FLT_RELAY] ##1 (state_reg == SRS_S_FAULT);
	endproperty
	a_relay_fault: assert property (p_relay_fault) else $error("relay feedback failure not latched");

	c_activate: cover property ($rose(o_safety_out1));
	c_fall_start: cover property ((kind == `SRS_KIND_FALL) && fall_go);
	c_block: cover property ($rose(block_reg));
	c_irq: cover property ($rose(o_irq));

endmodule : srs_core

// ===== srs_relay_model.sv
/*
 * far-side model: the two relay contact readbacks of the safety outputs.
 * assumes coil drive from the safety outputs; stuck models welded contacts.
 */
`timescale 1ns/1ps
module srs_relay_model #(
	parameter int unsigned LAG = 2
) (
	input  wire logic i_clk_sys,
	input  wire logic i_coil1,
	input  wire logic i_coil2,
	input  wire logic i_stuck,
	output logic      o_fb1,
	output logic      o_fb2
);
	logic [LAG-1:0] c1_reg = '0;
	logic [LAG-1:0] c2_reg = '0;
	// contacts follow the coils after a mechanical lag
	always_ff @(posedge i_clk_sys) begin
		c1_reg <= {c1_reg[LAG-2:0], i_coil1};
		c2_reg <= {c2_reg[LAG-2:0], i_coil2};
	end
	// a welded contact reads closed whatever the coil does
	assign o_fb1 = c1_reg[LAG-1] | i_stuck;
	assign o_fb2 = c2_reg[LAG-1] | i_stuck;
endmodule : srs_relay_model

// ===== testbench.sv
/*
 * self-checking bench of the start logic with a relay contact model.
 * assumes shortened timing parameters and register layout of srs_consts.svh.
 */
`timescale 1ns/1ps
`include "srs_consts.svh"
module testbench;
	import srs_pkg::*;
	logic clk = 0, rstn = 0, ch1 = 0, ch2 = 0, st = 0, wr = 0, rd = 0, stuck = 0;
	logic [4:0] mode = 5'h00;
	logic earth = 0, ishort = 0, sshort = 0, xshort = 0, expn = 1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic out1, out2, aux, fault, irq, fb1, fb2;
	srs_state_type state;
	int n_errors = 0, checks_done = 0;
	always #4 clk = ~clk;
	srs_core #(.ON_CYC(4), .OFF_CYC(4), .WAIT_CYC(8), .PULSE_CYC(4), .FB_CYC(10)) u_dut (
		.i_clk_sys(clk), .i_resetn(rstn), .i_input_ch1(ch1), .i_input_ch2(ch2),
		.i_start_input(st), .i_mode_sel(mode), .i_earth_fault(earth), .i_input_short(ishort),
		.i_start_short(sshort), .i_cross_short(xshort), .i_expansion_present(expn),
		.i_relay_fb1(fb1), .i_relay_fb2(fb2), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .o_safety_out1(out1), .o_safety_out2(out2),
		.o_aux_status_out(aux), .o_fault(fault), .o_irq(irq), .o_state(state));
	srs_relay_model #(.LAG(2)) u_relay (.i_clk_sys(clk), .i_coil1(out1), .i_coil2(out2),
		.i_stuck(stuck), .o_fb1(fb1), .o_fb2(fb2));
	////////////////////////////////////////////////////////////////////////
	task end_of_test;
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task rst(input logic [4:0] m);
		cyc(1);
		mode <= m; earth <= 0; ishort <= 0; sshort <= 0; xshort <= 0; expn <= 1;
		ch1 <= 0; ch2 <= 0; st <= 0; stuck <= 0; rstn <= 0;
		cyc(10);
		rstn <= 1;
		cyc(16);
	endtask : rst
	task wait_out(input logic v);
		int k;
		k = 0;
		while (out1 !== v && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk({aux, out2, out1}, {3{v}});
	endtask : wait_out
	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1; addr <= a; wdata <= d;
		@(posedge clk);
		wr <= 0;
	endtask : reg_wr
	task reg_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1; addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, e);
	endtask : reg_rd
	////////////////////////////////////////////////////////////////////////
	task t_auto;
		rst(5'h00);
		reg_wr(`SRS_ADDR_IRQ_EN, 32'h1);
		cyc(1); ch1 <= 1;
		cyc(5); #1 chk(out1, 0);
		wait_out(1);
		chk(state, SRS_S_ACTIVE);
		cyc(1); #1 chk(irq, 1);
		reg_rd(`SRS_ADDR_STATUS, 32'h1);
		reg_rd(`SRS_ADDR_IRQ_EN, 32'h1);
		reg_wr(`SRS_ADDR_IRQ_CLR, 32'h1);
		cyc(1); #1 chk(irq, 0);
		cyc(1); ch1 <= 0;
		cyc(4); #1 chk(out1, 1);
		wait_out(0);
		reg_rd(`SRS_ADDR_STATUS, 32'h2);
		chk(irq, 0);
		cyc(1); ch1 <= 1;
		wait_out(1);
		reg_rd(`SRS_ADDR_STATE, 32'h13);
		reg_rd(8'h40, 32'h0);
	endtask : t_auto
	task t_manual;
		rst(5'h01);
		cyc(1); ch1 <= 1;
		cyc(20); #1 chk(out1, 0);
		cyc(1); st <= 1;
		wait_out(1);
		cyc(1); st <= 0;
		wait_out(0);
	endtask : t_manual
	task t_fall;
		rst(5'h03);
		cyc(1); ch1 <= 1;
		cyc(10); st <= 1;
		cyc(2); st <= 0;
		cyc(20); #1 chk(out1, 0);
		cyc(1); st <= 1;
		cyc(10); #1 chk(out1, 0);
		cyc(1); st <= 0;
		wait_out(1);
	endtask : t_fall
	task t_rise;
		rst(5'h02);
		cyc(1); ch1 <= 1; st <= 1;
		cyc(20); #1 chk(out1, 0);
		cyc(1); st <= 0;
		cyc(6); st <= 1;
		wait_out(1);
	endtask : t_rise
	task t_sel;
		rst(`SRS_MODE_NEUTRAL);
		cyc(1); ch1 <= 1; st <= 1;
		cyc(30); #1 chk({fault, out1}, 2'h2);
		rst(5'h00);
		cyc(1); ch1 <= 1;
		wait_out(1);
		cyc(1); mode <= 5'h01;
		cyc(12); #1 chk({fault, out1}, 2'h2);
		cyc(1); mode <= 5'h00;
		cyc(30); #1 chk({fault, out1}, 2'h2);
		reg_rd(`SRS_ADDR_STATUS, 32'h7);
		reg_rd(`SRS_ADDR_STATE, 32'h205);
	endtask : t_sel
	task t_flt(input logic [4:0] f);
		rst(5'h12);
		cyc(1);
		earth <= f[0];
		ishort <= f[1];
		sshort <= f[2];
		xshort <= f[3];
		expn <= ~f[4];
		ch1 <= 1; ch2 <= 1; st <= 1;
		cyc(30); #1 chk({fault, out1}, 2'h2);
	endtask : t_flt
	task t_faults;
		t_flt(5'h01);
		t_flt(5'h02);
		t_flt(5'h04);
		t_flt(5'h08);
		t_flt(5'h10);
	endtask : t_faults
	task t_test;
		cyc(1);
		mode <= 5'h04; ch1 <= 1; st <= 0; rstn <= 0;
		cyc(10);
		rstn <= 1;
		cyc(30); #1 chk(out1, 0);
		cyc(1); ch1 <= 0;
		cyc(10); ch1 <= 1;
		wait_out(1);
	endtask : t_test
	task t_relay;
		rst(5'h00);
		cyc(1); ch1 <= 1;
		wait_out(1);
		cyc(1); stuck <= 1; ch1 <= 0;
		wait_out(0);
		cyc(20); #1 chk(fault, 1);
		cyc(1); ch1 <= 1;
		cyc(30); #1 chk(out1, 0);
	endtask : t_relay
	task t_block;
		rst(5'h08);
		cyc(1); ch1 <= 1; ch2 <= 1;
		wait_out(1);
		cyc(1); ch2 <= 0;
		cyc(3); ch2 <= 1;
		cyc(30); #1 chk({fault, out1}, 2'h2);
		reg_rd(`SRS_ADDR_STATUS, 32'hB);
		reg_rd(`SRS_ADDR_MODE, 32'h8);
		cyc(1); ch1 <= 0; ch2 <= 0;
		cyc(10); ch1 <= 1; ch2 <= 1;
		wait_out(1);
	endtask : t_block
	////////////////////////////////////////////////////////////////////////
	initial begin
		t_auto();
		t_manual();
		t_fall();
		t_rise();
		t_sel();
		t_faults();
		t_relay();
		t_block();
		t_test();
		end_of_test();
	end
	initial begin
		cyc(20000);
		n_errors++;
		end_of_test();
	end
endmodule : testbench
